// File: hw/tcp_timers.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// What this block does
// - 8-bit overflow counter runs on instruction clock or external clock.
// - External clock for the 8-bit counter counts rising or falling edge.
// - One prescaler serves either the 8-bit counter or the watchdog.
// - Rate field gives 1:2 to 1:256; 1:1 while watchdog owns prescaler.
// - External 8-bit counter clock is synchronised after the prescaler.
// - 16-bit timer runs on instruction clock, external clock or crystal.
// - Counter mode may be synchronous or asynchronous; async runs in sleep.
// - 16-bit timer prescaler offers 1:1, 1:2, 1:4 and 1:8.
// - 16-bit timer must be synchronous when used for capture or compare; here only compare is gated on it, capture is not.
// - 8-bit period timer with prescaler, postscaler and period register.
// - Period timer prescaler divides by 1, 4 or 16 only.
// - Postscaler counts 1 to 16 period matches before flagging.
// - Period timer is PWM time base and serial port baud source.
// - Each unit is in one mode: capture, compare or PWM.
// - Capture copies the full 16-bit timer value into the unit.
// - Capture on falling, rising, every fourth or sixteenth rising edge.
// - Compare match flags, drives pin, may clear timer, start conversion.
// - PWM drives pin low when period timer equals 10-bit duty.
// - Period match clears timer, steps postscaler, drives PWM pin high.
// - Each timer raises an interrupt request on its event.
// - Internal source: count instruction clock, ignore sync control.
// - External rising edges; synchronous mode stops in sleep, prescaler not.
module tcp_timers (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t0_ext_clk,
  input wire logic wdt_tick_in,
  output logic wdt_tick_out,
  input wire logic wide_ext_clk,
  input wire logic wide_xtal_clk,
  input wire logic sleep,
  input wire logic [tcp_pkg::NUM_CCU-1:0] cc_pin_in,
  output logic [tcp_pkg::NUM_CCU-1:0] cc_pin_out,
  output logic [tcp_pkg::NUM_CCU-1:0] cc_pin_oe,
  output logic [tcp_pkg::FLAG_W-1:0] irq_req,
  output logic conv_start,
  output logic ssp_baud_tick
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [7:0] option;
    logic [7:0] t0_val;
    logic [7:0] t0_pre;
    logic t0_ext_q;
    logic t0_sync;
    logic wdt_out;
    logic [7:0] wide_ctrl;
    logic [15:0] wide_val;
    logic [2:0] wide_pre;
    logic wide_clk_q;
    logic wide_sync;
    logic [7:0] per_ctrl;
    logic [7:0] per_val;
    logic [7:0] per_match;
    logic [3:0] per_pre;
    logic [3:0] per_post;
    logic per_wrap;
    logic [NUM_CCU-1:0][3:0] cc_mode;
    logic [FLAG_W-1:0] flags;
    logic [31:0] prdata;
  } tcp_main_st_t;

  tcp_main_st_t st_r;
  tcp_main_st_t st_nxt;
  tcp_ccu_out_t cc_out [NUM_CCU];
  logic [NUM_CCU-1:0][15:0] cc_value;
  logic [NUM_CCU-1:0] cc_wr;
  logic apb_wr;
  logic addr_ok;
  logic [31:0] rdata;
  logic [7:0] t0_mask;
  logic t0_edge;
  logic t0_src;
  logic t0_inc;
  logic wsel;
  logic w_src;
  logic w_async;
  logic w_pre_out;
  logic wide_inc;
  logic wide_clr;
  logic [2:0] w_mask;
  logic [3:0] p_mask;
  logic per_tick;
  logic [FLAG_W-1:0] fset;
  logic [FLAG_W-1:0] fclr;

  // ==========================================================
  // APB slave: zero wait states, ce low stretches the access
  // ==========================================================
  always_comb begin
    addr_ok = 1'b0;
    rdata = 32'h0000_0000;
    case (paddr)
      ADDR_OPTION: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.option;
      end
      ADDR_T0_VAL: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.t0_val;
      end
      ADDR_WIDE_CTRL: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.wide_ctrl;
      end
      ADDR_WIDE_VAL: begin
        addr_ok = 1'b1;
        rdata[15:0] = st_r.wide_val;
      end
      ADDR_PER_CTRL: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.per_ctrl;
      end
      ADDR_PER_VAL: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.per_val;
      end
      ADDR_PER_MATCH: begin
        addr_ok = 1'b1;
        rdata[7:0] = st_r.per_match;
      end
      ADDR_FLAGS: begin
        addr_ok = 1'b1;
        rdata[FLAG_W-1:0] = st_r.flags;
      end
      default: begin
        for (int i = 0; i < NUM_CCU; i++) begin
          if (paddr == cc_addr(i, 1'b0)) begin
            addr_ok = 1'b1;
            rdata[3:0] = st_r.cc_mode[i];
          end
          if (paddr == cc_addr(i, 1'b1)) begin
            addr_ok = 1'b1;
            rdata[15:0] = cc_value[i];
          end
        end
      end
    endcase
  end

  assign pready = ce;
  assign pslverr = psel & penable & ~addr_ok;
  assign apb_wr = psel & penable & pwrite & ce & addr_ok;
  assign t0_mask = 8'((9'h002 << st_r.option[OPT_RATE_LSB +: 3]) - 9'h001);
  assign w_mask = 3'((4'h1 << st_r.wide_ctrl[WC_PRE_LSB +: 2]) - 4'h1);

  // ==========================================================
  // Timer logic
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    st_nxt.t0_sync = 1'b0;
    st_nxt.wdt_out = 1'b0;
    st_nxt.wide_sync = 1'b0;
    st_nxt.per_wrap = 1'b0;
    fset = '0;
    fclr = '0;
    t0_inc = 1'b0;
    w_pre_out = 1'b0;
    wide_inc = 1'b0;
    per_tick = 1'b0;
    wide_clr = 1'b0;
    for (int i = 0; i < NUM_CCU; i++) begin
      wide_clr = wide_clr | cc_out[i].timer_clr;
      fset[FLG_CC_LSB + i] = cc_out[i].evt;
    end
    t0_edge = (t0_ext_clk ^ st_r.option[OPT_EDGE_BIT]) &
              ~(st_r.t0_ext_q ^ st_r.option[OPT_EDGE_BIT]);
    t0_src = st_r.option[OPT_SRC_BIT] ? t0_edge : 1'b1;
    wsel = st_r.wide_ctrl[WC_XTAL_BIT] ? wide_xtal_clk : wide_ext_clk;
    w_src = st_r.wide_ctrl[WC_SRC_BIT] ?
            (wsel & ~st_r.wide_clk_q) : 1'b1;
    w_async = st_r.wide_ctrl[WC_SRC_BIT] &
              st_r.wide_ctrl[WC_NOSYNC_BIT];
    p_mask = st_r.per_ctrl[PC_PRE_LSB + 1] ? PER_MASK_16 :
             (st_r.per_ctrl[PC_PRE_LSB] ? PER_MASK_4 : PER_MASK_1);
    if (ce) begin
      st_nxt.t0_ext_q = t0_ext_clk;
      st_nxt.wide_clk_q = wsel;
      if (st_r.option[OPT_ASSIGN_BIT]) begin
        // Watchdog owns the prescaler; counter sees every tick
        if (wdt_tick_in) begin
          st_nxt.t0_pre = st_r.t0_pre + 8'h01;
          st_nxt.wdt_out = ((st_r.t0_pre + 8'h01) & (t0_mask >> 1)) == 8'h00;
        end
        st_nxt.t0_sync = t0_src;
      end else if (t0_src) begin
        st_nxt.t0_pre = st_r.t0_pre + 8'h01;
        st_nxt.t0_sync = ((st_r.t0_pre + 8'h01) & t0_mask) == 8'h00;
      end
      // Only the registered prescaler output reaches the counter
      t0_inc = st_r.t0_sync & ~sleep;
      if (t0_inc) begin
        st_nxt.t0_val = st_r.t0_val + 8'h01;
        fset[FLG_T0] = (st_r.t0_val == 8'hFF);
      end
      if (st_r.wide_ctrl[WC_ON_BIT] && w_src) begin
        // Prescaler keeps running in sleep
        st_nxt.wide_pre = (st_r.wide_pre + 3'h1) & w_mask;
        w_pre_out = ((st_r.wide_pre + 3'h1) & w_mask) == 3'h0;
      end
      st_nxt.wide_sync = w_pre_out;
      if (w_async) begin
        wide_inc = w_pre_out;
      end else if (st_r.wide_ctrl[WC_SRC_BIT]) begin
        wide_inc = st_r.wide_sync & ~sleep & st_r.wide_ctrl[WC_ON_BIT];
      end else begin
        wide_inc = w_pre_out & ~sleep;
      end
      if (wide_clr) begin
        st_nxt.wide_val = 16'h0000;
      end else if (wide_inc) begin
        st_nxt.wide_val = st_r.wide_val + 16'h0001;
        fset[FLG_WIDE] = (st_r.wide_val == 16'hFFFF);
      end
      if (st_r.per_ctrl[PC_ON_BIT]) begin
        st_nxt.per_pre = (st_r.per_pre + 4'h1) & p_mask;
        per_tick = ((st_r.per_pre + 4'h1) & p_mask) == 4'h0;
      end
      if (per_tick) begin
        if (st_r.per_val == st_r.per_match) begin
          st_nxt.per_val = 8'h00;
          st_nxt.per_wrap = 1'b1;
          if (st_r.per_post == st_r.per_ctrl[PC_POST_LSB +: 4]) begin
            st_nxt.per_post = 4'h0;
            fset[FLG_PER] = 1'b1;
          end else begin
            st_nxt.per_post = st_r.per_post + 4'h1;
          end
        end else begin
          st_nxt.per_val = st_r.per_val + 8'h01;
        end
      end
      if (psel && !penable) begin
        st_nxt.prdata = rdata;
      end
      if (apb_wr) begin
        case (paddr)
          ADDR_OPTION: st_nxt.option = pwdata[7:0];
          ADDR_T0_VAL: begin
            st_nxt.t0_val = pwdata[7:0];
            st_nxt.t0_pre = 8'h00;
          end
          ADDR_WIDE_CTRL: st_nxt.wide_ctrl = pwdata[7:0];
          ADDR_WIDE_VAL: st_nxt.wide_val = pwdata[15:0];
          ADDR_PER_CTRL: st_nxt.per_ctrl = pwdata[7:0];
          ADDR_PER_VAL: begin
            st_nxt.per_val = pwdata[7:0];
            st_nxt.per_pre = 4'h0;
            st_nxt.per_post = 4'h0;
          end
          ADDR_PER_MATCH: st_nxt.per_match = pwdata[7:0];
          ADDR_FLAGS: fclr = pwdata[FLAG_W-1:0];
          default: begin
            for (int i = 0; i < NUM_CCU; i++) begin
              if (paddr == cc_addr(i, 1'b0)) begin
                st_nxt.cc_mode[i] = pwdata[3:0];
              end
            end
          end
        endcase
      end
      // Write-one-to-clear; a new event in the same cycle survives
      st_nxt.flags = (st_r.flags & ~fclr) | fset;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.per_match <= PER_MATCH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Capture/compare/PWM units
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < NUM_CCU; g++) begin : g_ccu
      assign cc_wr[g] = apb_wr && (paddr == cc_addr(g, 1'b1));
      tcp_ccu #(
        .IS_SECOND(g == 1)
      ) u_ccu (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .mode(tcp_ccmode_t'(st_r.cc_mode[g])),
        .wr_en(cc_wr[g]),
        .wr_data(pwdata[15:0]),
        .wide_value(st_r.wide_val),
        .wide_synced(~w_async),
        .period_fine({st_r.per_val, st_r.per_pre[1:0]}),
        .period_wrap(st_r.per_wrap),
        .pin_in(cc_pin_in[g]),
        .value(cc_value[g]),
        .ccu_out(cc_out[g])
      );
      assign cc_pin_out[g] = cc_out[g].pin_out;
      assign cc_pin_oe[g] = cc_out[g].pin_oe;
    end
  endgenerate

  assign prdata = st_r.prdata;
  assign wdt_tick_out = st_r.wdt_out;
  assign irq_req = st_r.flags;
  assign conv_start = cc_out[1].conv_start;
  assign ssp_baud_tick = st_r.per_wrap;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_t0_wrap;
    ce && t0_inc && st_r.t0_val == 8'hFF && !(apb_wr && paddr == ADDR_T0_VAL)
      |=> st_r.t0_val == 8'h00 && st_r.flags[FLG_T0];
  endproperty
  a_t0_wrap: assert property (p_t0_wrap)
    else $error("8-bit counter wrap not flagged");

  property p_wide_wrap;
    ce && wide_inc && !wide_clr && st_r.wide_val == 16'hFFFF &&
      !(apb_wr && paddr == ADDR_WIDE_VAL)
      |=> st_r.wide_val == 16'h0000 && st_r.flags[FLG_WIDE];
  endproperty
  a_wide_wrap: assert property (p_wide_wrap)
    else $error("16-bit timer wrap not flagged");

  property p_wdt_bypass;
    ce && st_r.option[OPT_ASSIGN_BIT] && !st_r.option[OPT_SRC_BIT]
      |=> st_r.t0_sync;
  endproperty
  a_wdt_bypass: assert property (p_wdt_bypass)
    else $error("counter not at 1:1 with watchdog prescaler");

  property p_t0_half;
    ce && st_r.t0_sync && $stable(st_r.option) && !st_r.option[OPT_SRC_BIT]
      && !st_r.option[OPT_ASSIGN_BIT] && st_r.option[2:0] == 3'h0
      |=> !st_r.t0_sync;
  endproperty
  a_t0_half: assert property (p_t0_half)
    else $error("1:2 prescaler ticked twice in a row");

  property p_async_sleep;
    ce && sleep && w_async && w_pre_out && !wide_clr &&
      !(apb_wr && paddr == ADDR_WIDE_VAL)
      |=> st_r.wide_val == $past(st_r.wide_val) + 16'h0001;
  endproperty
  a_async_sleep: assert property (p_async_sleep)
    else $error("asynchronous counter stalled in sleep");

  property p_sync_sleep;
    ce && sleep && !w_async && !wide_clr &&
      !(apb_wr && paddr == ADDR_WIDE_VAL)
      |=> $stable(st_r.wide_val);
  endproperty
  a_sync_sleep: assert property (p_sync_sleep)
    else $error("synchronous timer counted in sleep");

  sequence s_per_cleared;
    st_r.per_val == 8'h00 && st_r.per_wrap;
  endsequence
  property p_period_clear;
    ce && per_tick && st_r.per_val == st_r.per_match &&
      !(apb_wr && paddr == ADDR_PER_VAL)
      |=> s_per_cleared;
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("period timer not cleared on match");

  property p_postscale;
    ce && per_tick && st_r.per_val == st_r.per_match &&
      st_r.per_post == st_r.per_ctrl[PC_POST_LSB +: 4] &&
      !(apb_wr && paddr == ADDR_PER_VAL)
      |=> st_r.flags[FLG_PER] && st_r.per_post == 4'h0;
  endproperty
  a_postscale: assert property (p_postscale)
    else $error("postscaler did not flag after set count");

endmodule : tcp_timers

// File: hw/tcp_pkg.sv
package tcp_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================
  localparam int NUM_CCU = 2;
  localparam int FLAG_W = 5;
  localparam logic [7:0] ADDR_OPTION = 8'h00;
  localparam logic [7:0] ADDR_T0_VAL = 8'h04;
  localparam logic [7:0] ADDR_WIDE_CTRL = 8'h08;
  localparam logic [7:0] ADDR_WIDE_VAL = 8'h0C;
  localparam logic [7:0] ADDR_PER_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PER_VAL = 8'h14;
  localparam logic [7:0] ADDR_PER_MATCH = 8'h18;
  localparam logic [7:0] ADDR_CC_BASE = 8'h1C;
  localparam logic [7:0] ADDR_CC_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_CC_VAL_OFS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h2C;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_SRC_BIT = 5;
  localparam int WC_ON_BIT = 0;
  localparam int WC_SRC_BIT = 1;
  localparam int WC_NOSYNC_BIT = 2;
  localparam int WC_XTAL_BIT = 3;
  localparam int WC_PRE_LSB = 4;
  localparam int PC_PRE_LSB = 0;
  localparam int PC_ON_BIT = 2;
  localparam int PC_POST_LSB = 3;
  localparam int FLG_T0 = 0;
  localparam int FLG_WIDE = 1;
  localparam int FLG_PER = 2;
  localparam int FLG_CC_LSB = 3;

  // ==========================================================
  // Reset values and counts
  // ==========================================================
  localparam logic [7:0] PER_MATCH_RST = 8'hFF;
  localparam logic [3:0] PER_MASK_1 = 4'h0;
  localparam logic [3:0] PER_MASK_4 = 4'h3;
  localparam logic [3:0] PER_MASK_16 = 4'hF;
  localparam logic [3:0] CAP_DIV4_LAST = 4'h3;
  localparam logic [3:0] CAP_DIV16_LAST = 4'hF;

  typedef enum logic [3:0] {
    CCM_OFF = 4'h0,
    CCM_CAP_FALL = 4'h4,
    CCM_CAP_RISE = 4'h5,
    CCM_CAP_RISE4 = 4'h6,
    CCM_CAP_RISE16 = 4'h7,
    CCM_CMP_HIGH = 4'h8,
    CCM_CMP_LOW = 4'h9,
    CCM_CMP_FLAG = 4'hA,
    CCM_CMP_SPECIAL = 4'hB,
    CCM_PWM = 4'hC
  } tcp_ccmode_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic evt;
    logic timer_clr;
    logic conv_start;
  } tcp_ccu_out_t;

  function automatic logic [7:0] cc_addr(input int unit, input logic is_val);
    cc_addr = 8'(ADDR_CC_BASE + ADDR_CC_STRIDE * unit +
                 (is_val ? ADDR_CC_VAL_OFS : 8'h00));
  endfunction : cc_addr

endpackage : tcp_pkg

// File: hw/tcp_ccu.sv
`timescale 1ns/1ps
module tcp_ccu #(
  parameter bit IS_SECOND = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input tcp_pkg::tcp_ccmode_t mode,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] wide_value,
  input wire logic wide_synced,
  input wire logic [9:0] period_fine,
  input wire logic period_wrap,
  input wire logic pin_in,
  output logic [15:0] value,
  output tcp_pkg::tcp_ccu_out_t ccu_out
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [15:0] value;
    logic pin_q;
    logic [3:0] edge_cnt;
    logic pin_lvl;
    logic match_q;
    logic evt;
    logic tclr;
    logic conv;
  } tcp_ccu_st_t;

  tcp_ccu_st_t st_r;
  tcp_ccu_st_t st_nxt;
  logic rise;
  logic fall;
  logic capture;
  logic match;
  logic pwm;
  logic [9:0] duty;
  logic [3:0] last;

  assign duty = {st_r.value[15:8], st_r.value[5:4]};
  assign pwm = (mode[3:2] == 2'b11);

  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    st_nxt.tclr = 1'b0;
    st_nxt.conv = 1'b0;
    rise = pin_in & ~st_r.pin_q;
    fall = ~pin_in & st_r.pin_q;
    capture = 1'b0;
    last = (mode == CCM_CAP_RISE4) ? CAP_DIV4_LAST : CAP_DIV16_LAST;
    // Compare only against a clock-synchronous timer
    match = wide_synced && (wide_value == st_r.value);
    if (ce) begin
      st_nxt.pin_q = pin_in;
      st_nxt.match_q = match;
      if (mode != CCM_CAP_RISE4 && mode != CCM_CAP_RISE16) begin
        st_nxt.edge_cnt = 4'h0;
      end
      case (mode)
        CCM_CAP_FALL: capture = fall;
        CCM_CAP_RISE: capture = rise;
        CCM_CAP_RISE4, CCM_CAP_RISE16: begin
          if (rise) begin
            if (st_r.edge_cnt == last) begin
              st_nxt.edge_cnt = 4'h0;
              capture = 1'b1;
            end else begin
              st_nxt.edge_cnt = st_r.edge_cnt + 4'h1;
            end
          end
        end
        CCM_CMP_HIGH, CCM_CMP_LOW, CCM_CMP_FLAG, CCM_CMP_SPECIAL: begin
          // Edge of the match, so a slow timer flags once
          if (match && !st_r.match_q) begin
            st_nxt.evt = 1'b1;
            if (mode == CCM_CMP_HIGH) begin
              st_nxt.pin_lvl = 1'b1;
            end
            if (mode == CCM_CMP_LOW) begin
              st_nxt.pin_lvl = 1'b0;
            end
            if (mode == CCM_CMP_SPECIAL) begin
              st_nxt.tclr = 1'b1;
              st_nxt.conv = IS_SECOND;
            end
          end
        end
        default: begin
          if (pwm) begin
            if (period_wrap) begin
              st_nxt.pin_lvl = 1'b1;
            end
            // Duty match wins, so a zero duty gives a low pin
            if (period_fine == duty) begin
              st_nxt.pin_lvl = 1'b0;
            end
          end
        end
      endcase
      if (capture) begin
        st_nxt.value = wide_value;
        st_nxt.evt = 1'b1;
      end else if (wr_en) begin
        st_nxt.value = wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.value;
  assign ccu_out.pin_out = st_r.pin_lvl;
  assign ccu_out.pin_oe = mode[3];
  assign ccu_out.evt = st_r.evt;
  assign ccu_out.timer_clr = st_r.tclr;
  assign ccu_out.conv_start = st_r.conv;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_capture_copy;
    ce && mode == CCM_CAP_RISE && pin_in && !st_r.pin_q
      |=> value == $past(wide_value) && ccu_out.evt;
  endproperty
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture did not copy the timer");

  property p_div4;
    ccu_out.evt && $past(mode) == CCM_CAP_RISE4
      |-> $past(st_r.edge_cnt) == 4'h3;
  endproperty
  a_div4: assert property (p_div4)
    else $error("divide-by-four capture fired early");

  sequence s_cmp_hit;
    ce && mode == CCM_CMP_HIGH && match && !st_r.match_q;
  endsequence
  property p_cmp_high;
    s_cmp_hit |=> ccu_out.evt && ccu_out.pin_out;
  endproperty
  a_cmp_high: assert property (p_cmp_high)
    else $error("compare match did not drive pin high");

  property p_pwm_low;
    ce && pwm && period_fine == duty |=> !ccu_out.pin_out;
  endproperty
  a_pwm_low: assert property (p_pwm_low)
    else $error("pwm pin not low on duty match");

  property p_pwm_high;
    ce && pwm && period_wrap && period_fine != duty |=> ccu_out.pin_out;
  endproperty
  a_pwm_high: assert property (p_pwm_high)
    else $error("pwm pin not high at period start");

endmodule : tcp_ccu

// File: test/tcp_pins_model.sv
`timescale 1ns/1ps
// ==========================================================
// Capture pin source on the far side of the units
// ==========================================================
module tcp_pins_model (
  input wire logic clk,
  output logic [1:0] cc_pin,
  output logic ext_clk
);
  initial begin
    cc_pin = 2'h0;
    ext_clk = 1'b0;
  end

  // Wide low and high phases, so every edge is seen by the sampler
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      cc_pin[0] <= 1'b1;
      repeat (3) @(posedge clk);
      cc_pin[0] <= 1'b0;
    end
  endtask : pulse

  // External timer clock: two cycles high, two low, idle low between bursts
  task automatic tick(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (2) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : tick
endmodule : tcp_pins_model

// File: test/tcp_timers_bench.sv
`timescale 1ns/1ps
module tcp_timers_bench;
  import tcp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, slv, wdt_in, wdt_out;
  logic baud, conv, slp, ext;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cap;
  logic [1:0] pin_in, pin_out, pin_oe;
  logic [4:0] irq;
  wire [9:0] sig;
  int err_count, checks, seed, n, m, k, r;
  assign sig = {conv, wdt_out, baud, pin_out, irq};

  always #4 clk = ~clk;

  tcp_pins_model u_tcp_pins_model (.clk(clk), .cc_pin(pin_in), .ext_clk(ext));

  // Tied: ce and the crystal pin
  tcp_timers u_tcp_timers (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t0_ext_clk(ext),
    .wdt_tick_in(wdt_in), .wdt_tick_out(wdt_out), .wide_ext_clk(ext),
    .wide_xtal_clk(1'b0), .sleep(slp), .cc_pin_in(pin_in),
    .cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .irq_req(irq),
    .conv_start(conv), .ssp_baud_tick(baud)
  );

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts cycles until the watched output is seen high
  task automatic waitf(input int b);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sig[b] !== 1'b1 && n < 3000);
    chk(32'(sig[b]), 32'h1);
  endtask : waitf

  // Counter increments after a number of external edges at a given rate
  function automatic logic [31:0] t0_expect(input int edges,
                                            input int rate);
    return 32'(edges >> (rate + 1));
  endfunction : t0_expect

  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    seed = 32'h9307C929;
    {psel, penable, pwrite, wdt_in, slp} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_PER_MATCH, 32'h0);
    chk(rd, 32'(PER_MATCH_RST));
    apb(1'b0, 8'h30, 32'h0);
    chk(32'(slv), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_T0_VAL, 32'hF0);
    waitf(FLG_T0);
    apb(1'b0, ADDR_T0_VAL, 32'h0);
    chk(32'(rd < 32'h10), 32'h1);
    apb(1'b1, ADDR_OPTION, 32'h0A);
    wdt_in <= 1'b1;
    waitf(8);
    waitf(8);
    chk(32'(n), 32'h4);
    wdt_in <= 1'b0;
    r = $random(seed) & 1;
    k = 2 + ($random(seed) & 7);
    apb(1'b1, ADDR_OPTION, 32'h30 | 32'(r));
    apb(1'b1, ADDR_T0_VAL, 32'h0);
    u_tcp_pins_model.tick(k);
    apb(1'b0, ADDR_T0_VAL, 32'h0);
    chk(rd, t0_expect(k, r));
    apb(1'b1, ADDR_WIDE_VAL, 32'hFFF0);
    apb(1'b1, ADDR_WIDE_CTRL, 32'h5);
    waitf(FLG_WIDE);
    m = 6 + ($random(seed) & 7);
    apb(1'b1, ADDR_PER_MATCH, 32'(m));
    apb(1'b1, ADDR_PER_CTRL, 32'h4);
    waitf(7);
    waitf(7);
    chk(32'(n), 32'(m + 1));
    apb(1'b1, ADDR_PER_CTRL, 32'h1C);
    apb(1'b1, ADDR_PER_VAL, 32'h0);
    apb(1'b1, ADDR_FLAGS, 32'h1F);
    waitf(FLG_PER);
    chk(32'(n > 3 * (m + 1) && n <= 4 * (m + 1)), 32'h1);
    apb(1'b1, cc_addr(0, 1'b0), 32'(CCM_CAP_RISE4));
    u_tcp_pins_model.pulse(3);
    chk(32'(irq[FLG_CC_LSB]), 32'h0);
    u_tcp_pins_model.pulse(1);
    repeat (4) @(posedge clk);
    chk(32'(irq[FLG_CC_LSB]), 32'h1);
    apb(1'b0, cc_addr(0, 1'b1), 32'h0);
    cap = rd[15:0];
    apb(1'b0, ADDR_WIDE_VAL, 32'h0);
    chk(32'(16'(rd[15:0] - cap) < 16'd40), 32'h1);
    k = 1 + ($random(seed) & 3);
    apb(1'b1, cc_addr(0, 1'b1), 32'(k) << 8);
    apb(1'b1, cc_addr(0, 1'b0), 32'(CCM_PWM));
    waitf(5);
    repeat (k - 1) @(posedge clk);
    chk(32'(pin_out[0]), 32'h1);
    @(posedge clk);
    chk(32'(pin_out[0]), 32'h0);
    chk(32'(pin_oe[0]), 32'h1);
    apb(1'b1, cc_addr(1, 1'b1), 32'h200);
    apb(1'b1, cc_addr(1, 1'b0), 32'(CCM_CMP_HIGH));
    apb(1'b1, ADDR_WIDE_VAL, 32'h0);
    waitf(6);
    repeat (2) @(posedge clk);
    chk(32'({pin_oe[1], irq[FLG_CC_LSB + 1]}), 32'h3);
    apb(1'b1, cc_addr(1, 1'b0), 32'(CCM_CMP_SPECIAL));
    apb(1'b1, ADDR_WIDE_VAL, 32'h1F0);
    waitf(9);
    apb(1'b0, ADDR_WIDE_VAL, 32'h0);
    chk(32'(rd < 32'h10), 32'h1);
    slp <= 1'b1;
    apb(1'b1, ADDR_WIDE_CTRL, 32'h3);
    apb(1'b1, ADDR_WIDE_VAL, 32'h0);
    u_tcp_pins_model.tick(3);
    apb(1'b0, ADDR_WIDE_VAL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_WIDE_CTRL, 32'h7);
    u_tcp_pins_model.tick(k);
    apb(1'b0, ADDR_WIDE_VAL, 32'h0);
    chk(rd, 32'(k));
    slp <= 1'b0;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
endmodule : tcp_timers_bench
